// ---- rtl/tss_pkg.sv ----
`default_nettype none
package tss_pkg;
  // bus address prefix shared by the write and the read phase
  localparam logic [3:0]  ADDR_PREFIX    = 4'h3;
  localparam logic [7:0]  CMD_CAPS       = 8'h00;
  localparam logic [7:0]  CMD_CTRL       = 8'h01;
  localparam logic [7:0]  CMD_ALARM_HI   = 8'h02;
  localparam logic [7:0]  CMD_ALARM_LO   = 8'h03;
  localparam logic [7:0]  CMD_CRIT       = 8'h04;
  localparam logic [7:0]  CMD_TEMP       = 8'h05;
  localparam logic [7:0]  CMD_MAKER      = 8'h06;
  localparam logic [7:0]  CMD_PART       = 8'h07;
  localparam logic [7:0]  CMD_VEND_FIRST = 8'h08;
  localparam logic [7:0]  CMD_VEND_LAST  = 8'h0e;
  localparam logic [15:0] CAPS_RESET     = 16'h0017;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [15:0] UNUSED_READ    = 16'h0000;
  localparam int CLK_NS         = 8;
  localparam int REFRESH_MS     = 125;
  localparam int REFRESH_CYCLES = REFRESH_MS * 1000000 / CLK_NS;
  localparam int SCL_QTR_NS     = 2500;
  localparam int SCL_QTR_CYCLES = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
  // controller register indices on the command port
  localparam logic [2:0]  HREG_CTRL      = 3'h0;
  localparam logic [2:0]  HREG_PTR       = 3'h1;
  localparam logic [2:0]  HREG_WDATA     = 3'h2;
  localparam logic [2:0]  HREG_STATUS    = 3'h3;
  localparam logic [2:0]  HREG_RDATA     = 3'h4;
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_READ_BIT  = 1;
  localparam int CTRL_SEL_LSB   = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;
endpackage
`default_nettype wire

// ---- rtl/tss_bus_if.sv ----
`default_nettype none
interface tss_bus_if;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // pull-ups: a released line reads high, any active-low driver wins
  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
  modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
  modport host (input sda, output host_scl_out, output host_scl_oe_n,
                output host_sda_out, output host_sda_oe_n);
endinterface
`default_nettype wire

// ---- rtl/tss_sensor_slave.sv ----
// Functional notes
// (R01) address is 0011 then select pins bit2..bit0
// (R02) eighth address bit: low write, high read
// (R03) each byte: eight bits plus acknowledge
// (R04) slave pulls SDA low on ninth clock
// (R05) 16-bit registers move as two bytes
// (R06) write: addr, command, high, low, then stop
// (R07) command byte points; data loads that register
// (R08) read: command write, repeated start, address read
// (R09) read data sent from bit 15 down
// (R10) master acks high byte, nacks low, stops
// (R11) data changes only while SCL low
// (R12) start/stop are SDA edges with SCL high
// (R13) incoming bits taken on SCL rise
// (R14) temperature refreshed at least eight per second
// (R15) temperature latched for consistent reads
// (R16) power-up defaults: caps 0017h, others 0000h
// (R17) commands 08h-0Eh read as 0000h
// (R18) SDA only pulled low or released
// (R19) capability register ignores writes
// (R20) no address match: SDA stays released
// (R21) read phase uses same address prefix
//
// Chosen here: strobed register access.
`default_nettype none
module tss_sensor_slave #(
  parameter int          REFRESH_CYC = tss_pkg::REFRESH_CYCLES,
  parameter logic [15:0] MAKER_CODE  = 16'h0a5a, // arbitrary value
  parameter logic [15:0] PART_CODE   = 16'h0101  // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  tss_bus_if.device        bus,
  input  wire logic        addr_select_bit0,
  input  wire logic        addr_select_bit1,
  input  wire logic        addr_select_bit2,
  input  wire logic [15:0] temp_value,
  output logic      [15:0] control_settings,
  output logic      [15:0] alarm_high_limit,
  output logic      [15:0] alarm_low_limit,
  output logic      [15:0] critical_limit,
  output logic      [15:0] measured_temperature
);
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_CMD, PH_WHI, PH_WLO, PH_RHI, PH_RLO, PH_SKIP
  } tss_phase_t;

  localparam logic [4:0] PIN_IDLE = 5'b00011;

  logic [4:0]  pin_raw;
  logic [4:0]  s1_q;
  logic [4:0]  s2_q;
  logic [4:0]  s3_q;
  logic [4:0]  filt_q;
  logic [4:0]  prev_q;
  tss_phase_t  phase_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  ptr_q;
  logic [7:0]  hi_q;
  logic [15:0] tx_q;
  logic        rw_q;
  logic        mnack_q;
  logic        sda_low_q;
  logic [15:0] ctrl_q;
  logic [15:0] ahi_q;
  logic [15:0] alo_q;
  logic [15:0] crit_q;
  logic [15:0] temp_q;
  logic [31:0] ref_cnt_q;
  logic [15:0] rd_word;
  logic [3:0]  nxt_idx;
  logic        scl;
  logic        sda;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        addr_match;
  logic        wr_stb;

  assign pin_raw = {addr_select_bit2, addr_select_bit1, addr_select_bit0, bus.sda, bus.scl};

  // three stages; a level is taken only once stages two and three agree
  for (genvar i = 0; i < 5; i++) begin : g_pin
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        s1_q[i]   <= PIN_IDLE[i];
        s2_q[i]   <= PIN_IDLE[i];
        s3_q[i]   <= PIN_IDLE[i];
        filt_q[i] <= PIN_IDLE[i];
        prev_q[i] <= PIN_IDLE[i];
      end else begin
        s1_q[i]   <= pin_raw[i];
        s2_q[i]   <= s1_q[i];
        s3_q[i]   <= s2_q[i];
        filt_q[i] <= (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        prev_q[i] <= filt_q[i];
      end
    end
  end

  assign scl        = filt_q[0];
  assign sda        = filt_q[1];
  assign scl_rise   = scl & ~prev_q[0];
  assign scl_fall   = ~scl & prev_q[0];
  assign start_cond = scl & prev_q[0] & prev_q[1] & ~sda; // [R12]
  assign stop_cond  = scl & prev_q[0] & ~prev_q[1] & sda; // [R12]
  // same prefix for write and read phases [R01] [R21]
  assign addr_match = (shift_q[7:1] == {tss_pkg::ADDR_PREFIX, filt_q[4:2]});
  assign nxt_idx    = (phase_q == PH_RHI) ? 4'(4'd14 - bit_cnt_q) : 4'(4'd6 - bit_cnt_q);
  assign wr_stb     = scl_fall && (bit_cnt_q == 4'd7) && (phase_q == PH_WLO);

  always_comb begin
    rd_word = tss_pkg::UNUSED_READ; // vendor space and beyond [R17]
    unique case (ptr_q)
      tss_pkg::CMD_CAPS:     rd_word = tss_pkg::CAPS_RESET;
      tss_pkg::CMD_CTRL:     rd_word = ctrl_q;
      tss_pkg::CMD_ALARM_HI: rd_word = ahi_q;
      tss_pkg::CMD_ALARM_LO: rd_word = alo_q;
      tss_pkg::CMD_CRIT:     rd_word = crit_q;
      tss_pkg::CMD_TEMP:     rd_word = temp_q;
      tss_pkg::CMD_MAKER:    rd_word = MAKER_CODE;
      tss_pkg::CMD_PART:     rd_word = PART_CODE;
      default:               rd_word = tss_pkg::UNUSED_READ;
    endcase
  end

  // protocol engine; drives only on SCL falls so data moves while SCL low [R11]
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q   <= PH_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      hi_q      <= 8'h00;
      tx_q      <= 16'h0000;
      rw_q      <= 1'b0;
      mnack_q   <= 1'b1;
      sda_low_q <= 1'b0;
    end else if (start_cond) begin // also a repeated start [R08]
      phase_q   <= PH_ADDR;
      // the scl fall that closes the start is no data bit; it wraps this to zero
      bit_cnt_q <= 4'hf;
      sda_low_q <= 1'b0;
    end else if (stop_cond) begin
      phase_q   <= PH_IDLE;
      bit_cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (scl_rise && bit_cnt_q < 4'd8) begin
      shift_q <= {shift_q[6:0], sda}; // [R13]
    end else if (scl_rise) begin
      mnack_q <= sda; // master answer on ninth clock [R10]
    end else if (scl_fall && phase_q != PH_IDLE) begin
      if (bit_cnt_q == 4'd7) begin
        bit_cnt_q <= 4'd8; // ninth clock follows [R03]
        unique case (phase_q)
          PH_ADDR: begin
            if (addr_match) begin
              sda_low_q <= 1'b1; // [R04]
              rw_q      <= shift_q[0]; // [R02]
            end else begin
              phase_q <= PH_SKIP; // stay silent [R20]
            end
          end
          PH_CMD: begin
            ptr_q     <= shift_q; // [R07]
            sda_low_q <= 1'b1; // [R04]
          end
          PH_WHI: begin
            hi_q      <= shift_q; // [R05]
            sda_low_q <= 1'b1; // [R04]
          end
          PH_WLO:  sda_low_q <= 1'b1; // [R04]
          PH_RHI:  sda_low_q <= 1'b0;
          PH_RLO:  sda_low_q <= 1'b0;
          PH_SKIP: sda_low_q <= 1'b0;
          PH_IDLE: sda_low_q <= 1'b0;
        endcase
      end else if (bit_cnt_q == 4'd8) begin
        bit_cnt_q <= 4'h0;
        sda_low_q <= 1'b0;
        unique case (phase_q)
          PH_ADDR: begin
            if (rw_q) begin
              phase_q   <= PH_RHI;
              tx_q      <= rd_word; // snapshot keeps the word whole [R15]
              sda_low_q <= ~rd_word[15]; // [R09] [R18]
            end else begin
              phase_q <= PH_CMD;
            end
          end
          PH_CMD: phase_q <= PH_WHI;
          PH_WHI: phase_q <= PH_WLO;
          PH_WLO: phase_q <= PH_SKIP; // [R06]
          PH_RHI: begin
            if (mnack_q) begin
              phase_q <= PH_SKIP;
            end else begin
              phase_q   <= PH_RLO;
              sda_low_q <= ~tx_q[7]; // high byte first [R09]
            end
          end
          PH_RLO:  phase_q <= PH_SKIP;
          PH_SKIP: phase_q <= PH_SKIP;
          PH_IDLE: phase_q <= PH_IDLE;
        endcase
      end else begin
        bit_cnt_q <= 4'(bit_cnt_q + 4'd1);
        if (phase_q == PH_RHI || phase_q == PH_RLO) begin
          sda_low_q <= ~tx_q[nxt_idx]; // [R09] [R18]
        end
      end
    end
  end

  // register writes land on the fall ending the low byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= tss_pkg::REG_RESET; // [R16]
      ahi_q  <= tss_pkg::REG_RESET; // [R16]
      alo_q  <= tss_pkg::REG_RESET; // [R16]
      crit_q <= tss_pkg::REG_RESET; // [R16]
    end else if (wr_stb) begin
      unique case (ptr_q)
        tss_pkg::CMD_CTRL:     ctrl_q <= {hi_q, shift_q}; // [R07]
        tss_pkg::CMD_ALARM_HI: ahi_q  <= {hi_q, shift_q}; // [R07]
        tss_pkg::CMD_ALARM_LO: alo_q  <= {hi_q, shift_q}; // [R07]
        tss_pkg::CMD_CRIT:     crit_q <= {hi_q, shift_q}; // [R07]
        default:               ; // read-only and unused words keep value [R19]
      endcase
    end
  end

  // free-running refresh, no bus command involved
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_q <= 32'h0;
      temp_q    <= tss_pkg::REG_RESET; // [R16]
    end else if (ref_cnt_q == 32'(REFRESH_CYC - 1)) begin
      ref_cnt_q <= 32'h0;
      temp_q    <= temp_value; // [R14] [R15]
    end else begin
      ref_cnt_q <= ref_cnt_q + 32'h1;
    end
  end

  assign bus.dev_sda_out    = 1'b0; // never drives high [R18]
  assign bus.dev_sda_oe_n   = ~sda_low_q;
  assign control_settings     = ctrl_q;
  assign alarm_high_limit     = ahi_q;
  assign alarm_low_limit      = alo_q;
  assign critical_limit       = crit_q;
  assign measured_temperature = temp_q;
endmodule
`default_nettype wire

// ---- rtl/tss_bus_master.sv ----
`default_nettype none
module tss_bus_master #(
  parameter int QTR_CYC = tss_pkg::SCL_QTR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  tss_bus_if.host          bus,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tss_hstate_t;

  tss_hstate_t state_q;
  logic [1:0]  qtr_q;
  logic [15:0] tmr_q;
  logic [2:0]  byte_q;
  logic [3:0]  bit_q;
  logic        scl_low_q;
  logic        sda_low_q;
  logic [2:0]  sel_q;
  logic        read_q;
  logic [7:0]  ptr_q;
  logic [15:0] wdata_q;
  logic [15:0] rx_q;
  logic        nack_q;
  logic [2:0]  sda_sync_q;
  logic        sda_q;
  logic [15:0] rdata_q;
  logic        tick;
  logic        go;
  logic        rx_byte;
  logic [7:0]  tx_byte;
  logic        drv_bit;

  assign tick    = (state_q != H_IDLE) && (tmr_q == 16'h0);
  assign go      = reg_wr && (reg_addr == tss_pkg::HREG_CTRL)
                   && reg_wdata[tss_pkg::CTRL_GO_BIT] && (state_q == H_IDLE);
  assign rx_byte = read_q && (byte_q >= 3'd3);

  always_comb begin
    tx_byte = 8'hff;
    unique case (byte_q)
      3'd0:    tx_byte = {tss_pkg::ADDR_PREFIX, sel_q, 1'b0}; // [R01] [R02]
      3'd1:    tx_byte = ptr_q;
      3'd2:    tx_byte = read_q ? {tss_pkg::ADDR_PREFIX, sel_q, 1'b1} // [R21]
                                : wdata_q[15:8]; // [R05]
      3'd3:    tx_byte = wdata_q[7:0];
      default: tx_byte = 8'hff;
    endcase
    if (bit_q < 4'd8) begin
      drv_bit = rx_byte ? 1'b1 : tx_byte[3'(4'd7 - bit_q)];
    end else begin
      drv_bit = rx_byte ? (byte_q == 3'd4) : 1'b1; // ack high, nack low [R10]
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_sync_q <= 3'b111;
      sda_q      <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[1:0], bus.sda};
      sda_q      <= (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
    end
  end

  // quarter-period timer of the divided SCL
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= 16'h0;
    end else if (go || tick) begin
      tmr_q <= 16'(QTR_CYC - 1);
    end else if (state_q != H_IDLE) begin
      tmr_q <= tmr_q - 16'h1;
    end
  end

  // bit engine: in H_BIT, SDA only moves in quarter 0 while SCL is low [R11]
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= H_IDLE;
      qtr_q     <= 2'h0;
      byte_q    <= 3'h0;
      bit_q     <= 4'h0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      rx_q      <= 16'h0;
      nack_q    <= 1'b0;
    end else if (go) begin
      state_q <= H_START;
      qtr_q   <= 2'h0;
      byte_q  <= 3'h0;
      nack_q  <= 1'b0;
    end else if (tick) begin
      qtr_q <= 2'(qtr_q + 2'h1);
      unique case (state_q)
        H_START: begin
          unique case (qtr_q)
            2'd0: begin
              scl_low_q <= 1'b1;
              sda_low_q <= 1'b0;
            end
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b1; // start or repeated start [R08]
            2'd3: begin
              scl_low_q <= 1'b1;
              state_q   <= H_BIT;
              bit_q     <= 4'h0;
            end
          endcase
        end
        H_BIT: begin
          unique case (qtr_q)
            2'd0: sda_low_q <= ~drv_bit;
            2'd1: scl_low_q <= 1'b0;
            2'd2: begin
              if (bit_q < 4'd8 && rx_byte) begin
                rx_q <= {rx_q[14:0], sda_q}; // MSB first [R09]
              end else if (bit_q == 4'd8 && !rx_byte) begin
                nack_q <= sda_q;
              end
            end
            2'd3: begin
              scl_low_q <= 1'b1;
              if (bit_q < 4'd8) begin
                bit_q <= 4'(bit_q + 4'd1);
              end else begin
                bit_q <= 4'h0; // nine clocks per byte [R03]
                if (nack_q || (!read_q && byte_q == 3'd3) || byte_q == 3'd4) begin
                  state_q <= H_STOP; // stop after the last byte, or after a nacked written byte [R06] [R10]
                end else if (read_q && byte_q == 3'd1) begin
                  state_q <= H_START; // direction change [R08]
                  byte_q  <= 3'd2;
                end else begin
                  byte_q <= 3'(byte_q + 3'd1);
                end
              end
            end
          endcase
        end
        H_STOP: begin
          unique case (qtr_q)
            2'd0: sda_low_q <= 1'b1;
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b0;
            2'd3: state_q   <= H_IDLE;
          endcase
        end
        H_IDLE: state_q <= H_IDLE;
      endcase
    end
  end

  // software registers; settings change only while idle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q   <= 3'h0;
      read_q  <= 1'b0;
      ptr_q   <= 8'h00;
      wdata_q <= 16'h0000;
    end else if (reg_wr && state_q == H_IDLE) begin
      unique case (reg_addr)
        tss_pkg::HREG_CTRL: begin
          read_q <= reg_wdata[tss_pkg::CTRL_READ_BIT];
          sel_q  <= reg_wdata[tss_pkg::CTRL_SEL_LSB +: 3];
        end
        tss_pkg::HREG_PTR:   ptr_q   <= reg_wdata[7:0];
        tss_pkg::HREG_WDATA: wdata_q <= reg_wdata;
        default:             ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        tss_pkg::HREG_CTRL:   rdata_q <= {11'h0, sel_q, read_q, 1'b0};
        tss_pkg::HREG_PTR:    rdata_q <= {8'h00, ptr_q};
        tss_pkg::HREG_WDATA:  rdata_q <= wdata_q;
        tss_pkg::HREG_STATUS: rdata_q <= {14'h0, nack_q, state_q != H_IDLE};
        tss_pkg::HREG_RDATA:  rdata_q <= rx_q;
        default:              rdata_q <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata         = rdata_q;
  assign bus.host_scl_out  = 1'b0;
  assign bus.host_scl_oe_n = ~scl_low_q;
  assign bus.host_sda_out  = 1'b0;
  assign bus.host_sda_oe_n = ~sda_low_q;
endmodule
`default_nettype wire

// ---- tb/tss_link_asserts.sv ----
`default_nettype none
module tss_link_asserts #(
  parameter logic [2:0] STRAP = 3'h0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q;
  logic       hit_q;
  logic       rd_q;
  logic       miss_q;
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;
  wire        ninth = rise & (bit_q == 4'h8);
  wire        hit   = sh_q[7:1] == {4'h3, STRAP};
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q  <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (rise) sh_q <= {sh_q[6:0], sda};
    end
  end
  // bit and byte position inside the current frame
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst || start) begin
      bit_q  <= 4'h0;
      byte_q <= 3'h0;
    end else if (rise) begin
      bit_q <= ninth ? 4'h0 : bit_q + 4'h1;
      if (ninth && byte_q != 3'h7) byte_q <= byte_q + 3'h1;
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst || start) begin
      hit_q  <= 1'b0;
      rd_q   <= 1'b0;
      miss_q <= 1'b0;
    end else if (ninth && byte_q == 3'h0) begin
      hit_q  <= hit;
      rd_q   <= sh_q[0];
      miss_q <= ~hit;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_addr_hit;  ninth && byte_q == 3'h0 && hit; endsequence
  sequence s_addr_miss; ninth && byte_q == 3'h0 && !hit; endsequence
  sequence s_wr_ack;    ninth && byte_q != 3'h0 && byte_q <= 3'h3 && hit_q && !rd_q; endsequence
  sequence s_rd_ack;    ninth && byte_q != 3'h0 && hit_q && rd_q; endsequence
  sequence s_hold;      !dev_sda_oe_n [*8]; endsequence
  chk_open_drain: assert property (!dev_sda_out)
    else $error("device drove sda high");
  chk_oe_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device sda changed with scl high");
  chk_addr_ack: assert property (s_addr_hit |-> !sda)
    else $error("matching address not acknowledged");
  chk_addr_miss: assert property (s_addr_miss |-> sda)
    else $error("foreign address acknowledged");
  chk_miss_silent: assert property (miss_q |-> dev_sda_oe_n)
    else $error("device drove sda after address miss");
  chk_write_ack: assert property (s_wr_ack |-> !sda)
    else $error("written byte not acknowledged");
  chk_read_release: assert property (s_rd_ack |-> dev_sda_oe_n)
    else $error("device held sda in master ack slot");
  chk_drive_hold: assert property (rise && !dev_sda_oe_n |-> s_hold)
    else $error("device released sda during scl high");
endmodule
`default_nettype wire

// ---- tb/thermal_sensor_smbus_word_slave_tb_top.sv ----
`default_nettype none
module thermal_sensor_smbus_word_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // asymmetric strap so a reversed pin order is caught
  localparam logic [2:0]  STRAP   = 3'b110;
  localparam int          REFRESH = 200;
  localparam logic [15:0] MAKER   = 16'h1234; // arbitrary value
  localparam logic [15:0] PART    = 16'h0042; // arbitrary value
  logic        core_clk;
  logic        sys_rst;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] temp_value;
  logic [15:0] ctl;
  logic [15:0] ahi;
  logic [15:0] alo;
  logic [15:0] crit;
  logic [15:0] meas;
  logic [15:0] shadow [1:4];
  logic [15:0] exp_q [$];
  logic        pend = 1'b0;
  int          n_errors;
  int          checked;
  int          seed;
  tss_bus_if tss_bus_if_i ();
  tss_sensor_slave #(.REFRESH_CYC(REFRESH), .MAKER_CODE(MAKER), .PART_CODE(PART))
    tss_sensor_slave_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(tss_bus_if_i),
    .addr_select_bit0(STRAP[0]), .addr_select_bit1(STRAP[1]), .addr_select_bit2(STRAP[2]),
    .temp_value(temp_value), .control_settings(ctl), .alarm_high_limit(ahi),
    .alarm_low_limit(alo), .critical_limit(crit), .measured_temperature(meas));
  tss_bus_master #(.QTR_CYC(8)) tss_bus_master_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(tss_bus_if_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  tss_link_asserts #(.STRAP(STRAP)) tss_link_asserts_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .dev_sda_out(tss_bus_if_i.dev_sda_out),
    .dev_sda_oe_n(tss_bus_if_i.dev_sda_oe_n), .scl(tss_bus_if_i.scl), .sda(tss_bus_if_i.sda));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic xfer(input logic [2:0] sel, input logic rnw, input logic [7:0] cmd,
                      input logic [15:0] d, output logic nk);
    logic [15:0] st;
    int          i;
    wr(tss_pkg::HREG_WDATA, d);
    wr(tss_pkg::HREG_PTR, {8'h00, cmd});
    wr(tss_pkg::HREG_CTRL, {11'h000, sel, rnw, 1'b1});
    st = 16'hffff;
    for (i = 0; i < 4000 && st[tss_pkg::STAT_BUSY_BIT] !== 1'b0; i++) begin
      rd(tss_pkg::HREG_STATUS, st);
    end
    if (st[tss_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      n_errors++;
      $display("timeout waiting for transfer at %0t", $time);
      report_and_stop();
    end
    nk = st[tss_pkg::STAT_NACK_BIT];
  endtask
  task automatic read_word(input logic [7:0] cmd, input logic [15:0] want);
    logic [15:0] d;
    logic        nk;
    xfer(STRAP, 1'b1, cmd, 16'h0000, nk);
    chk(16'(nk), 16'h0000);
    exp_q.push_back(want);
    rd(tss_pkg::HREG_RDATA, d);
  endtask
  // read word shows in the cycle after the strobe
  always @(negedge core_clk) begin
    if (pend && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front());
    pend = reg_rd === 1'b1 && reg_addr === tss_pkg::HREG_RDATA;
  end
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    logic [15:0] d;
    logic        nk;
    int          r;
    seed       = 32'h458b8bca;
    n_errors   = 0;
    checked    = 0;
    sys_rst    = 1'b1;
    reg_addr   = 3'h0;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    temp_value = 16'($random(seed));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(ctl, tss_pkg::REG_RESET);
    chk(ahi, tss_pkg::REG_RESET);
    chk(alo, tss_pkg::REG_RESET);
    chk(crit, tss_pkg::REG_RESET);
    chk(meas, tss_pkg::REG_RESET);
    read_word(tss_pkg::CMD_CAPS, tss_pkg::CAPS_RESET);
    $display("test reset_defaults done");
    for (r = 1; r <= 4; r++) begin
      d = 16'($random(seed));
      shadow[r] = d;
      xfer(STRAP, 1'b0, 8'(r), d, nk);
      chk(16'(nk), 16'h0000);
      read_word(8'(r), d);
    end
    chk(ctl, shadow[1]);
    chk(ahi, shadow[2]);
    chk(alo, shadow[3]);
    chk(crit, shadow[4]);
    $display("test write_read_words done");
    xfer(STRAP, 1'b0, tss_pkg::CMD_CAPS, 16'($random(seed)), nk);
    chk(16'(nk), 16'h0000);
    read_word(tss_pkg::CMD_CAPS, tss_pkg::CAPS_RESET);
    read_word(tss_pkg::CMD_MAKER, MAKER);
    read_word(tss_pkg::CMD_PART, PART);
    xfer(STRAP, 1'b0, tss_pkg::CMD_VEND_FIRST, 16'hffff, nk);
    chk(16'(nk), 16'h0000);
    for (r = 8; r <= 14; r++) read_word(8'(r), tss_pkg::UNUSED_READ);
    $display("test read_only_and_unused done");
    // a new sample must land within one refresh period
    @(posedge core_clk);
    temp_value <= 16'($random(seed));
    repeat (REFRESH + 2) @(posedge core_clk);
    @(negedge core_clk);
    chk(meas, temp_value);
    read_word(tss_pkg::CMD_TEMP, temp_value);
    $display("test temperature done");
    for (r = 0; r < 8; r++) begin
      if (3'(r) != STRAP) begin
        xfer(3'(r), 1'b0, tss_pkg::CMD_CTRL, 16'hffff, nk);
        chk(16'(nk), 16'h0001);
      end
    end
    chk(ctl, shadow[1]);
    $display("test foreign_address done");
    chk(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
